//--- verilog/ssir_regs.sv
/*
 Status, interrupt cause, target ID and selection timeout registers of a
 SCSI protocol controller. Assumes the sequence engines, FIFO and transfer
 counter outside deliver one-cycle event pulses on this clock, and that the
 host port is synchronous to it.
*/
// Strobed register access was left to the implementer.
`include "ssir_cfg.svh"

module ssir_regs (
	input  wire logic       clock,
	input  wire logic       sys_rst,
	input  wire logic       soft_rst,
	input  wire logic [3:0] addr,
	input  wire logic [7:0] wr_data,
	input  wire logic       wr_stb,
	input  wire logic       rd_stb,
	output logic      [7:0] rd_data,
	output logic            int_out,
	input  wire logic [2:0] bus_phase_pin,
	input  wire logic       bus_reset_pin,
	input  wire logic       atn_pin,
	input  wire logic       dma_dir_clash,
	input  wire logic       fifo_overflow,
	input  wire logic       sync_phase_change,
	input  wire logic       cmd_overwrite,
	input  wire logic       parity_error,
	input  wire logic       count_reached_zero,
	input  wire logic       count_load_nonzero,
	input  wire logic       nop_issued,
	input  wire logic       nop_dma,
	input  wire logic       cdb_group_seen,
	input  wire logic [2:0] cdb_group,
	output ssir_pkg::ssir_cdb_len_type cdb_length,
	input  wire logic       cmd_done,
	input  wire logic       cmd_undefined,
	input  wire logic       cmd_wrong_role,
	input  wire logic       target_term_disc,
	input  wire logic       init_target_disc,
	input  wire logic       init_steps_cmd,
	input  wire logic       init_select_ok,
	input  wire logic       init_cmd_ok,
	input  wire logic       init_xfer_msgin,
	input  wire logic       target_cmd_done,
	input  wire logic       reselected_end,
	input  wire logic       selected_end,
	input  wire logic       sel_start,
	input  wire logic       sel_answered,
	input  wire logic [2:0] seq_state_in,
	input  wire logic       seq_state_load,
	input  wire logic [2:0] clock_conversion_factor,
	output ssir_pkg::ssir_role_type role,
	output logic      [2:0] target_id,
	output logic            sel_timer_running
);
	// -------------------------------------------------------------
	// Pin synchronisers
	// -------------------------------------------------------------
	logic [4:0] pin_s1_q;
	logic [4:0] pin_s2_q;
	logic       rst_pin_d1_q;
	logic       atn_d1_q;
	logic [2:0] live_phase;
	logic       bus_rst_rise;
	logic       atn_rise;

	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			pin_s1_q     <= 5'h00;
			pin_s2_q     <= 5'h00;
			rst_pin_d1_q <= 1'b0;
			atn_d1_q     <= 1'b0;
		end else begin
			pin_s1_q     <= {atn_pin, bus_reset_pin, bus_phase_pin};
			pin_s2_q     <= pin_s1_q;
			rst_pin_d1_q <= pin_s2_q[3];
			atn_d1_q     <= pin_s2_q[4];
		end
	end

	assign live_phase   = pin_s2_q[2:0];
	assign bus_rst_rise = pin_s2_q[3] & ~rst_pin_d1_q;
	assign atn_rise     = pin_s2_q[4] & ~atn_d1_q;

	// -------------------------------------------------------------
	// Address decode
	// -------------------------------------------------------------
	logic rd_status;
	logic rd_cause;
	logic rd_seq;
	logic rd_c1;
	logic rd_c2;
	logic wr_tid;
	logic wr_tmo;
	logic wr_c1;
	logic wr_c2;
	logic clr_all;

	// Same offset splits by direction
	assign rd_status = rd_stb & (addr == `SSIR_OFS_STATUS);
	assign rd_cause  = rd_stb & (addr == `SSIR_OFS_CAUSE);
	assign rd_seq    = rd_stb & (addr == `SSIR_OFS_SEQ_STATE);
	assign rd_c1     = rd_stb & (addr == `SSIR_OFS_CONTROL_ONE);
	assign rd_c2     = rd_stb & (addr == `SSIR_OFS_CONTROL_TWO);
	assign wr_tid    = wr_stb & (addr == `SSIR_OFS_TARGET_ID);
	assign wr_tmo    = wr_stb & (addr == `SSIR_OFS_TIMEOUT);
	assign wr_c1     = wr_stb & (addr == `SSIR_OFS_CONTROL_ONE);
	assign wr_c2     = wr_stb & (addr == `SSIR_OFS_CONTROL_TWO);
	assign clr_all   = rd_cause | soft_rst;

	// -------------------------------------------------------------
	// Control and write-only registers
	// -------------------------------------------------------------
	logic [7:0] control_one_q;
	logic [7:0] control_two_q;
	logic [7:0] timeout_value_q;
	logic [2:0] target_id_q;
	logic       bus_reset_report_ctl;
	logic       features_enable;
	logic       scsi2_feature_enable;

	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			control_one_q   <= `SSIR_RESET_BYTE;
			control_two_q   <= `SSIR_RESET_BYTE;
			timeout_value_q <= `SSIR_RESET_BYTE;
		end else begin
			if (wr_c1)
				control_one_q <= wr_data;
			if (wr_c2)
				control_two_q <= wr_data;
			if (wr_tmo)
				timeout_value_q <= wr_data;
		end
	end

	// No reset: value survives hard and soft reset
	always_ff @(posedge clock) begin
		if (wr_tid)
			target_id_q <= wr_data[2:0];
	end

	assign bus_reset_report_ctl = control_one_q[`SSIR_C1_RST_REPORT];
	assign features_enable      = control_two_q[`SSIR_C2_FEATURES];
	assign scsi2_feature_enable = control_two_q[`SSIR_C2_SCSI2];
	assign target_id            = target_id_q;

	// -------------------------------------------------------------
	// Role tracking
	// -------------------------------------------------------------
	ssir_pkg::ssir_role_type role_q;
	ssir_pkg::ssir_role_type role_d;

	always_comb begin
		role_d = role_q;
		case (role_q)
			ssir_pkg::SSIR_ROLE_IDLE: begin
				if (selected_end)
					role_d = ssir_pkg::SSIR_ROLE_TARGET;
				else if (reselected_end | init_select_ok)
					role_d = ssir_pkg::SSIR_ROLE_INITIATOR;
			end
			ssir_pkg::SSIR_ROLE_INITIATOR: begin
				if (init_target_disc)
					role_d = ssir_pkg::SSIR_ROLE_IDLE;
			end
			ssir_pkg::SSIR_ROLE_TARGET: begin
				if (target_term_disc)
					role_d = ssir_pkg::SSIR_ROLE_IDLE;
			end
			default: role_d = ssir_pkg::SSIR_ROLE_IDLE;
		endcase
	end

	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst)
			role_q <= ssir_pkg::SSIR_ROLE_IDLE;
		else if (soft_rst)
			role_q <= ssir_pkg::SSIR_ROLE_IDLE;
		else
			role_q <= role_d;
	end

	assign role = role_q;

	logic is_idle;
	logic is_init;
	logic is_targ;
	assign is_idle = (role_q == ssir_pkg::SSIR_ROLE_IDLE);
	assign is_init = (role_q == ssir_pkg::SSIR_ROLE_INITIATOR);
	assign is_targ = (role_q == ssir_pkg::SSIR_ROLE_TARGET);

	// -------------------------------------------------------------
	// Selection timer
	// -------------------------------------------------------------
	ssir_tmo_if tmo ();
	assign tmo.timeout_value           = timeout_value_q;
	assign tmo.clock_conversion_factor = clock_conversion_factor;
	assign tmo.start                   = sel_start;
	assign tmo.stop                    = sel_answered;
	assign sel_timer_running           = tmo.running;

	ssir_sel_timer ssir_sel_timer_i (
		.clock   (clock),
		.sys_rst (sys_rst),
		.tmo     (tmo)
	);

	// -------------------------------------------------------------
	// Interrupt cause events
	// -------------------------------------------------------------
	logic [7:0] cause_set;
	assign cause_set[`SSIR_IC_RST]    = bus_rst_rise & bus_reset_report_ctl;
	assign cause_set[`SSIR_IC_BADCMD] = cmd_undefined | cmd_wrong_role;
	assign cause_set[`SSIR_IC_DISC]   = (is_targ & target_term_disc) | (is_init & init_target_disc)
		| (is_idle & tmo.expired);
	assign cause_set[`SSIR_IC_SREQ]   = (is_targ & atn_rise) | (is_init & init_steps_cmd);
	assign cause_set[`SSIR_IC_SO]     = (is_targ & target_cmd_done)
		| (is_init & (init_select_ok | init_cmd_ok | init_xfer_msgin));
	assign cause_set[`SSIR_IC_RESELECTED_FLAG]  = reselected_end;
	assign cause_set[`SSIR_IC_SELECTED_ATTN_FLAG]   = selected_end & pin_s2_q[4];
	assign cause_set[`SSIR_IC_SEL]    = selected_end & ~pin_s2_q[4];

	// -------------------------------------------------------------
	// Sticky flags; a set in the clearing cycle wins
	// -------------------------------------------------------------
	logic [7:0] cause_q;
	logic       int_q;
	logic       illegal_op_flag_q;
	logic       parity_error_flag_q;
	logic       count_zero_flag_q;
	logic       group_code_valid_flag_q;
	logic [2:0] seq_state_q;
	logic [2:0] phase_latch_q;
	logic       phase_held_q;
	logic       illegal_set;
	logic       parity_set;
	logic       count_clr;
	logic       gcv_set;
	logic       parity_enabled;

	assign illegal_set    = dma_dir_clash | fifo_overflow | (is_init & sync_phase_change) | cmd_overwrite;
	// Checking options live in control one 5:4 and control two 2:0
	assign parity_enabled = (|control_one_q[5:4]) | (|control_two_q[2:0]);
	assign parity_set     = parity_error & parity_enabled;
	assign count_clr      = count_load_nonzero | (nop_issued & nop_dma);
	assign gcv_set        = cdb_group_seen & ((cdb_group == 3'h0) | (cdb_group == 3'h1) | (cdb_group == 3'h5)
		| ((cdb_group == 3'h2) & scsi2_feature_enable));

	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			cause_q                 <= `SSIR_RESET_BYTE;
			int_q                   <= 1'b0;
			illegal_op_flag_q       <= 1'b0;
			parity_error_flag_q     <= 1'b0;
			count_zero_flag_q       <= 1'b0;
			group_code_valid_flag_q <= 1'b0;
			seq_state_q             <= 3'h0;
			phase_latch_q           <= 3'h0;
			phase_held_q            <= 1'b0;
		end else begin
			cause_q           <= (clr_all ? `SSIR_RESET_BYTE : cause_q) | cause_set;
			int_q             <= (int_q & ~clr_all) | (|cause_set);
			illegal_op_flag_q <= (illegal_op_flag_q & ~clr_all) | illegal_set;
			parity_error_flag_q <= (parity_error_flag_q & ~clr_all) | parity_set;
			group_code_valid_flag_q <= (group_code_valid_flag_q & ~clr_all) | gcv_set;
			// Cause read leaves count-zero alone
			if (count_reached_zero)
				count_zero_flag_q <= 1'b1;
			else if (count_clr | soft_rst)
				count_zero_flag_q <= 1'b0;
			if (seq_state_load)
				seq_state_q <= seq_state_in;
			else if (clr_all)
				seq_state_q <= 3'h0;
			if (cmd_done & features_enable) begin
				phase_latch_q <= live_phase;
				phase_held_q  <= 1'b1;
			end else if (clr_all) begin
				phase_held_q  <= 1'b0;
			end
		end
	end

	always_comb begin
		case (cdb_group)
			3'h1, 3'h2: cdb_length = scsi2_feature_enable || (cdb_group == 3'h1) ?
				ssir_pkg::SSIR_CDB_TEN : ssir_pkg::SSIR_CDB_SIX;
			3'h5:       cdb_length = ssir_pkg::SSIR_CDB_TEN;
			3'h6:       cdb_length = ssir_pkg::SSIR_CDB_VU_SIX;
			3'h7:       cdb_length = ssir_pkg::SSIR_CDB_VU_TEN;
			default:    cdb_length = ssir_pkg::SSIR_CDB_SIX;
		endcase
	end

	// -------------------------------------------------------------
	// Read data
	// -------------------------------------------------------------
	logic [2:0] shown_phase;
	logic [7:0] status_word;
	logic [7:0] rd_next;
	logic [7:0] rd_data_q;

	assign shown_phase = (features_enable & phase_held_q) ? phase_latch_q : live_phase;
	assign status_word = {int_q, illegal_op_flag_q, parity_error_flag_q, count_zero_flag_q,
		group_code_valid_flag_q, shown_phase};
	assign rd_next = rd_status ? status_word :
		rd_cause ? cause_q :
		rd_seq   ? {5'h00, seq_state_q} :
		rd_c1    ? control_one_q :
		rd_c2    ? control_two_q : `SSIR_RESET_BYTE;

	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst)
			rd_data_q <= `SSIR_RESET_BYTE;
		else
			rd_data_q <= rd_next;
	end

	assign rd_data = rd_data_q;
	assign int_out = int_q;
endmodule

//--- verilog/ssir_cfg.svh
/*
 Offsets, field positions, reset values and timing counts for the SCSI
 status and interrupt register group. Assumes inclusion by bare name.
*/
`ifndef SSIR_CFG_SVH
`define SSIR_CFG_SVH
`define SSIR_ADDR_W           4
`define SSIR_OFS_TARGET_ID    4'h4
`define SSIR_OFS_CAUSE        4'h5
`define SSIR_OFS_STATUS       4'h4
`define SSIR_OFS_TIMEOUT      4'h5
`define SSIR_OFS_SEQ_STATE    4'h6
`define SSIR_OFS_CONTROL_ONE  4'h8
`define SSIR_OFS_CONTROL_TWO  4'hB
`define SSIR_ST_INT           7
`define SSIR_ST_IOE           6
`define SSIR_ST_PE            5
`define SSIR_ST_CTZ           4
`define SSIR_ST_GCV           3
`define SSIR_IC_RST           7
`define SSIR_IC_BADCMD        6
`define SSIR_IC_DISC          5
`define SSIR_IC_SREQ          4
`define SSIR_IC_SO            3
`define SSIR_IC_RESELECTED_FLAG         2
`define SSIR_IC_SELECTED_ATTN_FLAG          1
`define SSIR_IC_SEL           0
`define SSIR_C1_RST_REPORT    6
`define SSIR_C2_FEATURES      6
`define SSIR_C2_SCSI2         3
`define SSIR_TIMEOUT_UNIT     8192
`define SSIR_RESET_BYTE       8'h00
`endif

//--- verilog/ssir_pkg.sv
/*
 Types for the SCSI status and interrupt register group.
 Assumes ssir_cfg.svh is compiled alongside.
*/
package ssir_pkg;
	typedef enum logic [1:0] {
		SSIR_ROLE_IDLE,
		SSIR_ROLE_INITIATOR,
		SSIR_ROLE_TARGET,
		SSIR_ROLE_SPARE
	} ssir_role_type;

	typedef enum logic [2:0] {
		SSIR_PH_DATA_OUT,
		SSIR_PH_DATA_IN,
		SSIR_PH_COMMAND,
		SSIR_PH_STATUS,
		SSIR_PH_RES4,
		SSIR_PH_RES5,
		SSIR_PH_MSG_OUT,
		SSIR_PH_MSG_IN
	} ssir_phase_type;

	typedef enum logic [1:0] {
		SSIR_CDB_SIX,
		SSIR_CDB_TEN,
		SSIR_CDB_VU_SIX,
		SSIR_CDB_VU_TEN
	} ssir_cdb_len_type;
endpackage

//--- verilog/ssir_tmo_if.sv
/*
 Carrier between the register group and its selection timer.
 Assumes one clock shared by both ends.
*/
interface ssir_tmo_if;
	logic [7:0] timeout_value;
	logic [2:0] clock_conversion_factor;
	logic       start;
	logic       stop;
	logic       expired;
	logic       running;
	modport regs  (output timeout_value, output clock_conversion_factor, output start, output stop,
		input expired, input running);
	modport timer (input timeout_value, input clock_conversion_factor, input start, input stop,
		output expired, output running);
endinterface

//--- verilog/ssir_sel_timer.sv
/*
 Selection and reselection timeout counter.
 Assumes start and stop are single-cycle pulses from the register group.
*/
`include "ssir_cfg.svh"
module ssir_sel_timer #(
	parameter int UNIT = `SSIR_TIMEOUT_UNIT
) (
	input  wire logic clock,
	input  wire logic sys_rst,
	ssir_tmo_if.timer tmo
);
	// -------------------------------------------------------------
	// Timeout = value * UNIT * factor clock periods
	// -------------------------------------------------------------
	logic [31:0] limit;
	logic [31:0] cnt_q;
	logic        run_q;
	logic        exp_q;
	logic [31:0] unit_w;
	logic [3:0]  factor;

	// Factor 0 behaves as 8, as in the clock conversion field
	assign factor = (tmo.clock_conversion_factor == 3'h0) ? 4'h8 : {1'b0, tmo.clock_conversion_factor};
	assign unit_w = 32'(UNIT);
	assign limit  = 32'({24'h00_0000, tmo.timeout_value} * unit_w * {28'h000_0000, factor});
	assign tmo.expired = exp_q;
	assign tmo.running = run_q;

	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			cnt_q <= 32'h0000_0000;
			run_q <= 1'b0;
			exp_q <= 1'b0;
		end else begin
			exp_q <= 1'b0;
			if (tmo.start) begin
				cnt_q <= 32'h0000_0001;
				run_q <= 1'b1;
			end else if (tmo.stop) begin
				run_q <= 1'b0;
			end else if (run_q) begin
				cnt_q <= cnt_q + 32'h0000_0001;
				if (cnt_q >= limit) begin
					run_q <= 1'b0;
					exp_q <= 1'b1;
				end
			end
		end
	end
endmodule

//--- verif/ssir_regs_asserts.sv
/*
 Checker for the status and interrupt register group.
 Assumes it is bound to ssir_regs and sees only its ports.
*/
`include "ssir_cfg.svh"
module ssir_regs_asserts (
	input wire logic                       clock,
	input wire logic                       sys_rst,
	input wire logic                       soft_rst,
	input wire logic [3:0]                 addr,
	input wire logic [7:0]                 wr_data,
	input wire logic                       wr_stb,
	input wire logic                       rd_stb,
	input wire logic [7:0]                 rd_data,
	input wire logic                       int_out,
	input wire logic                       cmd_undefined,
	input wire logic [2:0]                 cdb_group,
	input wire ssir_pkg::ssir_cdb_len_type cdb_length,
	input wire logic                       sel_start,
	input wire logic                       sel_answered,
	input wire logic                       sel_timer_running,
	input wire logic [2:0]                 target_id
);
	// --------------------------------
	// Properties
	// --------------------------------
	default clocking cb @(posedge clock);
	endclocking
	default disable iff (sys_rst);
	sequence s_cause_read;
		rd_stb && addr == `SSIR_OFS_CAUSE;
	endsequence
	sequence s_tid_write;
		wr_stb && addr == `SSIR_OFS_TARGET_ID;
	endsequence
	property p_rd_idle;
		!rd_stb |=> rd_data == 8'h00;
	endproperty
	property p_int_rise;
		cmd_undefined && !soft_rst |-> ##[1:2] int_out;
	endproperty
	// Only a cause read or soft reset may drop a pending interrupt
	property p_int_fall;
		$fell(int_out) |-> $past(rd_stb && addr == `SSIR_OFS_CAUSE) || $past(soft_rst);
	endproperty
	property p_cause_nz;
		s_cause_read ##0 int_out |=> rd_data != 8'h00;
	endproperty
	property p_cdb_vu;
		cdb_group[2:1] == 2'b11 |-> cdb_length == (cdb_group[0] ? ssir_pkg::SSIR_CDB_VU_TEN : ssir_pkg::SSIR_CDB_VU_SIX);
	endproperty
	property p_cdb_res;
		cdb_group inside {3'h3, 3'h4} |-> cdb_length == ssir_pkg::SSIR_CDB_SIX;
	endproperty
	property p_tmo_start;
		$rose(sel_timer_running) |-> $past(sel_start) || $past(sel_start, 2) || $past(sel_start, 3);
	endproperty
	property p_tmo_stop;
		sel_answered |-> ##[1:3] !sel_timer_running;
	endproperty
	property p_tid;
		s_tid_write |=> target_id == $past(wr_data[2:0]);
	endproperty
	a_rd_idle: assert property (p_rd_idle) else $error("read data not zero outside a read");
	a_int_rise: assert property (p_int_rise) else $error("bad command gave no interrupt");
	a_int_fall: assert property (p_int_fall) else $error("interrupt dropped without cause read");
	a_cause_nz: assert property (p_cause_nz) else $error("pending interrupt read as empty cause");
	a_cdb_vu: assert property (p_cdb_vu) else $error("vendor group length wrong");
	a_cdb_res: assert property (p_cdb_res) else $error("reserved group not six bytes");
	a_tmo_start: assert property (p_tmo_start) else $error("timer ran without a start");
	a_tmo_stop: assert property (p_tmo_stop) else $error("timer kept running after answer");
	a_tid: assert property (p_tid) else $error("target id not loaded");
endmodule
bind ssir_regs ssir_regs_asserts ssir_regs_asserts_i (
	.clock, .sys_rst, .soft_rst, .addr, .wr_data, .wr_stb, .rd_stb, .rd_data, .int_out, .cmd_undefined,
	.cdb_group, .cdb_length, .sel_start, .sel_answered, .sel_timer_running, .target_id
);

//--- verif/ssir_bus_peer.sv
/*
 Other initiators and targets on the bus: phase, reset and attention lines.
 Assumes the bench calls its tasks; lines change just after a clock edge.
*/
module ssir_bus_peer (
	input  wire logic       clock,
	output logic      [2:0] bus_phase_pin,
	output logic            bus_reset_pin,
	output logic            atn_pin
);
	timeunit 1ns;
	timeprecision 1ps;
	initial begin
		bus_phase_pin = 3'h0;
		bus_reset_pin = 1'b0;
		atn_pin = 1'b0;
	end
	task set_phase(input logic [2:0] p);
		@(posedge clock);
		bus_phase_pin <= p;
	endtask
	task set_atn(input logic a);
		@(posedge clock);
		atn_pin <= a;
	endtask
	// Held for several cycles so the synchroniser cannot miss it
	task pulse_reset;
		@(posedge clock);
		bus_reset_pin <= 1'b1;
		repeat (4) @(posedge clock);
		bus_reset_pin <= 1'b0;
	endtask
endmodule

//--- verif/scsi_status_interrupt_regs_test.sv
/*
 Self-checking bench for the status and interrupt register group.
 Assumes the design, checker and bus peer are compiled before it.
*/
`include "ssir_cfg.svh"
module scsi_status_interrupt_regs_test;
	timeunit 1ns;
	timeprecision 1ps;
	logic                       clock, sys_rst, nop_dma, rd_stb, wr_stb, int_out, sel_timer_running;
	logic                       bus_reset_pin, atn_pin;
	logic [3:0]                 addr;
	logic [7:0]                 wr_data, rd_data, d;
	logic [2:0]                 cdb_group, seq_state_in, clock_conversion_factor, target_id, bus_phase_pin;
	logic [24:0]                ev;
	ssir_pkg::ssir_cdb_len_type cdb_length;
	ssir_pkg::ssir_role_type    role;
	int                         errors, checks_done, n;
	string                      tname;
	int                         cev [14] = '{10, 11, 20, 18, 30, 20, 12, 31, 19, 14, 15, 16, 17, 13};
	logic [7:0]                 cexp [14] = '{8'h40, 8'h40, 8'h01, 8'h08, 8'h10, 8'h02, 8'h20, 8'h00,
		8'h04, 8'h10, 8'h08, 8'h08, 8'h08, 8'h20};
	ssir_bus_peer ssir_bus_peer_i (.clock, .bus_phase_pin, .bus_reset_pin, .atn_pin);
	ssir_regs ssir_regs_i (
		.clock, .sys_rst, .soft_rst(ev[24]), .addr, .wr_data, .wr_stb, .rd_stb, .rd_data, .int_out,
		.bus_phase_pin, .bus_reset_pin, .atn_pin, .dma_dir_clash(ev[0]), .fifo_overflow(ev[1]),
		.sync_phase_change(ev[2]), .cmd_overwrite(ev[3]), .parity_error(ev[4]), .count_reached_zero(ev[5]),
		.count_load_nonzero(ev[6]), .nop_issued(ev[7]), .nop_dma, .cdb_group_seen(ev[8]), .cdb_group,
		.cdb_length, .cmd_done(ev[9]), .cmd_undefined(ev[10]), .cmd_wrong_role(ev[11]),
		.target_term_disc(ev[12]), .init_target_disc(ev[13]), .init_steps_cmd(ev[14]),
		.init_select_ok(ev[15]), .init_cmd_ok(ev[16]), .init_xfer_msgin(ev[17]), .target_cmd_done(ev[18]),
		.reselected_end(ev[19]), .selected_end(ev[20]), .sel_start(ev[21]), .sel_answered(ev[22]),
		.seq_state_in, .seq_state_load(ev[23]), .clock_conversion_factor, .role, .target_id, .sel_timer_running
	);
	initial begin
		clock = 1'b0;
		forever #10 clock = ~clock;
	end
	// --------------------------------
	// Shared tasks
	// --------------------------------
	task chk(input logic [7:0] got, input logic [7:0] exp);
		checks_done++;
		if (got !== exp) begin
			errors++;
			$display("CHECK FAILED t=%0t %s: got %h expected %h", $time, tname, got, exp);
		end
	endtask
	task summarize;
		$display("checks %0d mismatches %0d", checks_done, errors);
		if (errors == 0 && checks_done > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask
	// Strobes drop one edge later, so a following access never collides
	task wr(input logic [3:0] a, input logic [7:0] v);
		@(posedge clock);
		addr <= a;
		wr_data <= v;
		wr_stb <= 1'b1;
		@(posedge clock);
		wr_stb <= 1'b0;
	endtask
	task rd(input logic [3:0] a);
		@(posedge clock);
		addr <= a;
		rd_stb <= 1'b1;
		@(posedge clock);
		rd_stb <= 1'b0;
		#1 d = rd_data;
	endtask
	task pulse(input int i);
		@(posedge clock);
		ev[i] <= 1'b1;
		@(posedge clock);
		ev[i] <= 1'b0;
	endtask
	task idle(input int c);
		repeat (c) @(posedge clock);
		#1;
	endtask
	// --------------------------------
	// Scenarios
	// --------------------------------
	task t_reset;
		tname = "reset and map";
		rd(`SSIR_OFS_STATUS);
		chk(d, 8'h00);
		rd(4'hF);
		chk(d, 8'h00);
		seq_state_in <= 3'h5;
		pulse(23);
		rd(`SSIR_OFS_SEQ_STATE);
		chk(d, 8'h05);
		rd(`SSIR_OFS_CAUSE);
		rd(`SSIR_OFS_SEQ_STATE);
		chk(d, 8'h00);
		wr(`SSIR_OFS_TARGET_ID, 8'hFD);
		idle(1);
		chk(target_id, 8'h05);
		rd(`SSIR_OFS_STATUS);
		chk(d, 8'h00);
		sys_rst <= 1'b1;
		idle(16);
		sys_rst <= 1'b0;
		chk(target_id, 8'h05);
		$display("test %s finished", tname);
	endtask
	task t_flags;
		tname = "status flags";
		for (int i = 0; i < 4; i++) begin
			// Phase change only counts in initiator role
			if (i == 2) begin
				pulse(15);
			end
			pulse(i);
			idle(2);
			chk(int_out, 1'b0);
			if (i == 2) begin
				chk(role, 8'h01);
			end
			rd(`SSIR_OFS_STATUS);
			chk(d, 8'h40);
			rd(`SSIR_OFS_CAUSE);
			rd(`SSIR_OFS_STATUS);
			chk(d, 8'h00);
		end
		pulse(4);
		rd(`SSIR_OFS_STATUS);
		chk(d, 8'h00);
		wr(`SSIR_OFS_CONTROL_ONE, 8'h30);
		pulse(4);
		idle(2);
		chk(int_out, 1'b0);
		rd(`SSIR_OFS_STATUS);
		chk(d, 8'h20);
		pulse(24);
		rd(`SSIR_OFS_STATUS);
		chk(d, 8'h00);
		pulse(5);
		rd(`SSIR_OFS_CAUSE);
		pulse(7);
		rd(`SSIR_OFS_STATUS);
		chk(d, 8'h10);
		nop_dma <= 1'b1;
		pulse(7);
		rd(`SSIR_OFS_STATUS);
		chk(d, 8'h00);
		pulse(5);
		pulse(6);
		rd(`SSIR_OFS_STATUS);
		chk(d, 8'h00);
		$display("test %s finished", tname);
	endtask
	task t_group;
		tname = "group code";
		for (int s = 0; s < 2; s++) begin
			wr(`SSIR_OFS_CONTROL_TWO, s ? 8'h08 : 8'h00);
			for (int g = 0; g < 8; g++) begin
				cdb_group <= g[2:0];
				pulse(8);
				if (g > 1 && g != 5) begin
					chk(cdb_length, g > 5 ? g - 4 : (g == 2 && s == 1));
				end
				rd(`SSIR_OFS_STATUS);
				chk(d, (g < 2 || g == 5 || (g == 2 && s == 1)) ? 8'h08 : 8'h00);
				rd(`SSIR_OFS_CAUSE);
				rd(`SSIR_OFS_STATUS);
				chk(d, 8'h00);
			end
		end
		$display("test %s finished", tname);
	endtask
	// Pins pass a two-flop synchroniser, hence the waits after each change
	task t_phase;
		tname = "phase bits";
		wr(`SSIR_OFS_CONTROL_TWO, 8'h00);
		for (int p = 0; p < 8; p++) begin
			ssir_bus_peer_i.set_phase(p[2:0]);
			idle(4);
			rd(`SSIR_OFS_STATUS);
			chk(d, p[7:0]);
		end
		wr(`SSIR_OFS_CONTROL_TWO, 8'h40);
		ssir_bus_peer_i.set_phase(3'h3);
		idle(4);
		pulse(9);
		ssir_bus_peer_i.set_phase(3'h1);
		idle(4);
		rd(`SSIR_OFS_STATUS);
		chk(d & 8'h07, 8'h03);
		rd(`SSIR_OFS_CAUSE);
		rd(`SSIR_OFS_STATUS);
		chk(d & 8'h07, 8'h01);
		wr(`SSIR_OFS_CONTROL_TWO, 8'h00);
		ssir_bus_peer_i.set_phase(3'h0);
		$display("test %s finished", tname);
	endtask
	task t_causes;
		tname = "interrupt causes";
		for (int k = 0; k < 14; k++) begin
			if (cev[k] > 24) begin
				ssir_bus_peer_i.set_atn(cev[k] == 30);
				idle(5);
			end else begin
				pulse(cev[k]);
				idle(2);
			end
			chk(int_out, cexp[k] != 0);
			rd(`SSIR_OFS_STATUS);
			chk(d[7], cexp[k] != 0);
			rd(`SSIR_OFS_CAUSE);
			chk(d, cexp[k]);
			chk(int_out, 1'b0);
			if (k == 2) begin
				chk(role, 8'h02);
			end
		end
		chk(role, 8'h00);
		ssir_bus_peer_i.pulse_reset;
		idle(5);
		rd(`SSIR_OFS_CAUSE);
		chk(d, 8'h00);
		wr(`SSIR_OFS_CONTROL_ONE, 8'h40);
		ssir_bus_peer_i.pulse_reset;
		idle(5);
		rd(`SSIR_OFS_CAUSE);
		chk(d, 8'h80);
		$display("test %s finished", tname);
	endtask
	task t_timeout;
		tname = "selection timeout";
		pulse(24);
		wr(`SSIR_OFS_TIMEOUT, 8'h01);
		pulse(21);
		idle(4);
		chk(sel_timer_running, 1'b1);
		n = 4;
		while (int_out !== 1'b1 && n < 9000) begin
			idle(1);
			n++;
		end
		chk(n >= 8192 && n <= 8198, 1'b1);
		if (n >= 9000) begin
			summarize;
		end
		rd(`SSIR_OFS_CAUSE);
		chk(d, 8'h20);
		pulse(21);
		idle(10);
		pulse(22);
		idle(5);
		chk(sel_timer_running, 1'b0);
		idle(8300);
		chk(int_out, 1'b0);
		clock_conversion_factor <= 3'h7;
		wr(`SSIR_OFS_TIMEOUT, 8'hDA); // about 250 ms at 50 MHz, factor 7
		pulse(21);
		idle(300);
		chk(sel_timer_running, 1'b1);
		chk(int_out, 1'b0);
		pulse(22);
		$display("test %s finished", tname);
	endtask
	initial begin
		sys_rst = 1'b1;
		{rd_stb, wr_stb, nop_dma} = 3'h0;
		{addr, wr_data, cdb_group, seq_state_in} = '0;
		ev = '0;
		clock_conversion_factor = 3'h1;
		errors = 0;
		checks_done = 0;
		repeat (16) @(posedge clock);
		sys_rst <= 1'b0;
		t_reset;
		t_flags;
		t_group;
		t_phase;
		t_causes;
		t_timeout;
		summarize;
	end
endmodule
